// >>> inc/tcc_consts.vh
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH
// register byte addresses
`define TCC_ADDR_CTRL 12'h000
`define TCC_ADDR_COUNT 12'h004
`define TCC_ADDR_CMPA 12'h008
`define TCC_ADDR_CMPB 12'h00C
`define TCC_ADDR_FLAGS 12'h010
`define TCC_ADDR_FORCE 12'h014
`define TCC_ADDR_PORT 12'h018
// control field positions
`define TCC_CTRL_MODE_LSB 0
`define TCC_CTRL_ACTA_LSB 4
`define TCC_CTRL_ACTB_LSB 6
`define TCC_CTRL_PRESC_LSB 8
// flag bits
`define TCC_FLAG_OVF 0
`define TCC_FLAG_MATCHA 1
`define TCC_FLAG_MATCHB 2
// force / ack bits
`define TCC_FORCE_A 0
`define TCC_FORCE_B 1
// port register bits
`define TCC_PORT_DATA_LSB 0
`define TCC_PORT_DIR_LSB 2
// reset values
`define TCC_RST_CTRL 11'h000
`define TCC_RST_BYTE 8'h00
// waveform modes
`define TCC_MODE_NORMAL 3'h0
`define TCC_MODE_CTC 3'h2
// compare actions
`define TCC_ACT_NONE 2'h0
`define TCC_ACT_TOGGLE 2'h1
`define TCC_ACT_CLEAR 2'h2
`define TCC_ACT_SET 2'h3
// prescale select codes
`define TCC_PS_STOP 3'h0
`define TCC_PS_1 3'h1
`define TCC_PS_8 3'h2
`define TCC_PS_32 3'h3
`define TCC_PS_64 3'h4
`define TCC_PS_128 3'h5
`define TCC_PS_256 3'h6
`define TCC_PS_1024 3'h7
`define TCC_MAX_COUNT 8'hFF
`endif

// >>> src/tcc_timer8.v
`timescale 1ns/100ps
`include "tcc_consts.vh"
module tcc_timer8 #(
	parameter PRESC_WIDTH = 10
)(
	input wire ref_clk,
	input wire rst,
	input wire clkEn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ovfIntAck,
	input wire matchAIntAck,
	input wire matchBIntAck,
	output reg [1:0] compareOutputState,
	output reg [1:0] pinOut,
	output reg [1:0] pinOutEn,
	output reg overflowFlag,
	output reg chanAMatchFlag,
	output reg chanBMatchFlag
);
	reg [10:0] ctrl_q;
	reg [7:0] counterValue_q;
	reg [7:0] cmpA_q;
	reg [7:0] cmpB_q;
	reg [1:0] portData_q;
	reg [1:0] portDir_q;
	reg [PRESC_WIDTH-1:0] presc_q;
	reg blockMatch_q;
	reg [1:0] matchPend_q;
	reg [2:0] ackSync1_q;
	reg [2:0] ackSync2_q;

	wire [2:0] waveformModeSel = ctrl_q[`TCC_CTRL_MODE_LSB+2:`TCC_CTRL_MODE_LSB];
	wire [1:0] chanAActionSel = ctrl_q[`TCC_CTRL_ACTA_LSB+1:`TCC_CTRL_ACTA_LSB];
	wire [1:0] chanBActionSel = ctrl_q[`TCC_CTRL_ACTB_LSB+1:`TCC_CTRL_ACTB_LSB];
	wire [2:0] prescSel = ctrl_q[`TCC_CTRL_PRESC_LSB+2:`TCC_CTRL_PRESC_LSB];
	wire [3:0] actPair = {chanBActionSel, chanAActionSel};
	wire nonPwm = (waveformModeSel == `TCC_MODE_NORMAL) || (waveformModeSel == `TCC_MODE_CTC);
	wire isCtc = (waveformModeSel == `TCC_MODE_CTC);

	wire acc = psel && penable && pready;
	wire wrAcc = acc && pwrite;
	wire wrCtrl = wrAcc && (paddr == `TCC_ADDR_CTRL);
	wire wrCount = wrAcc && (paddr == `TCC_ADDR_COUNT);
	wire wrCmpA = wrAcc && (paddr == `TCC_ADDR_CMPA);
	wire wrCmpB = wrAcc && (paddr == `TCC_ADDR_CMPB);
	wire wrFlags = wrAcc && (paddr == `TCC_ADDR_FLAGS);
	wire wrForce = wrAcc && (paddr == `TCC_ADDR_FORCE);
	wire wrPort = wrAcc && (paddr == `TCC_ADDR_PORT);
	wire mapped = (paddr == `TCC_ADDR_CTRL) || (paddr == `TCC_ADDR_COUNT)
		|| (paddr == `TCC_ADDR_CMPA) || (paddr == `TCC_ADDR_CMPB)
		|| (paddr == `TCC_ADDR_FLAGS) || (paddr == `TCC_ADDR_FORCE)
		|| (paddr == `TCC_ADDR_PORT);

	// prescaled timer clock enable
	reg timerTick;
	always @*
	begin
		case (prescSel)
			`TCC_PS_1: timerTick = 1'b1;
			`TCC_PS_8: timerTick = (presc_q[2:0] == 3'h7);
			`TCC_PS_32: timerTick = (presc_q[4:0] == 5'h1F);
			`TCC_PS_64: timerTick = (presc_q[5:0] == 6'h3F);
			`TCC_PS_128: timerTick = (presc_q[6:0] == 7'h7F);
			`TCC_PS_256: timerTick = (presc_q[7:0] == 8'hFF);
			`TCC_PS_1024: timerTick = (presc_q[9:0] == 10'h3FF);
			default: timerTick = 1'b0;
		endcase
	end

	wire [1:0] rawMatch = {counterValue_q == cmpB_q, counterValue_q == cmpA_q};
	wire [1:0] match = rawMatch & {2{~blockMatch_q}};
	wire ctcClear = isCtc && match[0];
	wire [7:0] countNext = ctcClear ? 8'h00 : counterValue_q + 8'h01;
	wire wrapToZero = (counterValue_q == `TCC_MAX_COUNT) && !ctcClear;

	always @(posedge ref_clk)
	begin
		if (rst)
			presc_q <= {PRESC_WIDTH{1'b0}};
		else if (clkEn)
			presc_q <= (prescSel == `TCC_PS_STOP) ? {PRESC_WIDTH{1'b0}} : presc_q + 1'b1;
	end

	// control, compare and port registers
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctrl_q <= `TCC_RST_CTRL;
			cmpA_q <= `TCC_RST_BYTE;
			cmpB_q <= `TCC_RST_BYTE;
			portData_q <= 2'h0;
			portDir_q <= 2'h0;
		end
		else if (clkEn)
		begin
			if (wrCtrl)
				ctrl_q <= pwdata[10:0];
			if (wrCmpA)
				cmpA_q <= pwdata[7:0];
			if (wrCmpB)
				cmpB_q <= pwdata[7:0];
			if (wrPort)
			begin
				portData_q <= pwdata[`TCC_PORT_DATA_LSB+1:`TCC_PORT_DATA_LSB];
				portDir_q <= pwdata[`TCC_PORT_DIR_LSB+1:`TCC_PORT_DIR_LSB];
			end
		end
	end

	// counter: software write has priority
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			counterValue_q <= `TCC_RST_BYTE;
			blockMatch_q <= 1'b0;
		end
		else if (clkEn)
		begin
			if (wrCount)
			begin
				counterValue_q <= pwdata[7:0];
				blockMatch_q <= 1'b1;
			end
			else if (timerTick)
			begin
				counterValue_q <= countNext;
				blockMatch_q <= 1'b0;
			end
		end
	end

	// interrupt acknowledges arrive from the outside: synchronise
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			ackSync1_q <= 3'h0;
			ackSync2_q <= 3'h0;
		end
		else if (clkEn)
		begin
			ackSync1_q <= {matchBIntAck, matchAIntAck, ovfIntAck};
			ackSync2_q <= ackSync1_q;
		end
	end

	// flags: hardware set wins over any clear
	wire [2:0] flagClr = (wrFlags ? pwdata[2:0] : 3'h0) | ackSync2_q;
	wire ovfSet = timerTick && !wrCount && wrapToZero;
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			overflowFlag <= 1'b0;
			chanAMatchFlag <= 1'b0;
			chanBMatchFlag <= 1'b0;
			matchPend_q <= 2'h0;
		end
		else if (clkEn)
		begin
			if (timerTick)
				matchPend_q <= match;
			if (ovfSet)
				overflowFlag <= 1'b1;
			else if (flagClr[`TCC_FLAG_OVF])
				overflowFlag <= 1'b0;
			if (timerTick && matchPend_q[0])
				chanAMatchFlag <= 1'b1;
			else if (flagClr[`TCC_FLAG_MATCHA])
				chanAMatchFlag <= 1'b0;
			if (timerTick && matchPend_q[1])
				chanBMatchFlag <= 1'b1;
			else if (flagClr[`TCC_FLAG_MATCHB])
				chanBMatchFlag <= 1'b0;
		end
	end

	// compare output state and pin stage per channel
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : gChan
			wire [1:0] act = actPair[2*ch+1:2*ch];
			wire forceHit = wrForce && pwdata[ch] && nonPwm;
			wire doAct = (timerTick && match[ch] && !wrCount) || forceHit;
			reg nextState;
			always @*
			begin
				case (act)
					`TCC_ACT_TOGGLE: nextState = ~compareOutputState[ch];
					`TCC_ACT_CLEAR: nextState = 1'b0;
					`TCC_ACT_SET: nextState = 1'b1;
					default: nextState = compareOutputState[ch];
				endcase
			end
			always @(posedge ref_clk)
			begin
				if (rst)
				begin
					compareOutputState[ch] <= 1'b0;
					pinOut[ch] <= 1'b0;
					pinOutEn[ch] <= 1'b0;
				end
				else if (clkEn)
				begin
					if (doAct && nonPwm)
						compareOutputState[ch] <= nextState;
					pinOut[ch] <= (act != `TCC_ACT_NONE) ? compareOutputState[ch]
						: portData_q[ch];
					pinOutEn[ch] <= portDir_q[ch];
				end
			end
		end
	endgenerate

	// APB slave: no wait state, ready in the first access cycle
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else if (clkEn)
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					`TCC_ADDR_CTRL: prdata <= {21'h000000, ctrl_q};
					`TCC_ADDR_COUNT: prdata <= {24'h000000, counterValue_q};
					`TCC_ADDR_CMPA: prdata <= {24'h000000, cmpA_q};
					`TCC_ADDR_CMPB: prdata <= {24'h000000, cmpB_q};
					`TCC_ADDR_FLAGS: prdata <= {29'h00000000, chanBMatchFlag,
						chanAMatchFlag, overflowFlag};
					`TCC_ADDR_PORT: prdata <= {26'h0000000, compareOutputState,
						portDir_q, portData_q};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// >>> verification/tcc_pin_load.sv
`timescale 1ns/100ps
module tcc_pin_load (
	input wire [1:0] pinOut,
	input wire [1:0] pinOutEn,
	output wire [1:0] pinLevel
);
	// pull-up holds a released pin high
	assign pinLevel = (pinOut & pinOutEn) | ~pinOutEn;
endmodule

// >>> verification/tcc_timer8_properties.sv
`timescale 1ns/100ps
module tcc_timer8_chk (
	input wire ref_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire ovfIntAck,
	input wire [1:0] compareOutputState,
	input wire [1:0] pinOut,
	input wire [1:0] pinOutEn,
	input wire overflowFlag,
	input wire chanAMatchFlag
);
	reg [1:0] act_q;
	reg [3:0] port_q;
	reg [4:0] ack_q;
	wire wr = psel && penable && pready && pwrite;
	// shadow of the fields that steer the pin
	always @(posedge ref_clk)
	begin
		ack_q <= {ack_q[3:0], ovfIntAck};
		if (rst)
		begin
			act_q <= 2'h0;
			port_q <= 4'h0;
		end
		else
		begin
			if (wr && paddr == 12'h000)
				act_q <= pwdata[5:4];
			if (wr && paddr == 12'h018)
				port_q <= pwdata[3:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_reset_zero: assert property (disable iff (1'h0) rst |=>
		compareOutputState == 2'h0 && !overflowFlag && !chanAMatchFlag)
		else $error("state after reset");
	a_ovf_clear_cause: assert property ($fell(overflowFlag) |->
		ack_q != 5'h00 || $past(wr && paddr == 12'h010 && pwdata[0]))
		else $error("overflow flag lost");
	a_pin_follows_state: assert property ($past(act_q) != 2'h0 |->
		pinOut[0] == $past(compareOutputState[0]))
		else $error("pin not overridden");
	a_pin_port_data: assert property ($past(act_q) == 2'h0 && $stable(port_q) |->
		pinOut[0] == port_q[0])
		else $error("pin not port data");
	a_pin_dir_drive: assert property ($stable(port_q) |-> pinOutEn == port_q[3:2])
		else $error("drive enable wrong");
	cover property (wr && paddr == 12'h014);
	cover property ($rose(overflowFlag));
	cover property ($rose(chanAMatchFlag) && pinOutEn[0]);
endmodule
bind tcc_timer8 tcc_timer8_chk u_tcc_timer8_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .ovfIntAck(ovfIntAck), .compareOutputState(compareOutputState),
	.pinOut(pinOut), .pinOutEn(pinOutEn), .overflowFlag(overflowFlag),
	.chanAMatchFlag(chanAMatchFlag));

// >>> verification/test_tcc_timer8.sv
`timescale 1ns/100ps
module test_tcc_timer8;
	localparam [19:0] ACTS = 20'h32110;
	localparam [4:0] EXPS = 5'h14;
	reg ref_clk, rst, clkEn, psel, penable, pwrite, ovfIntAck, matchAIntAck, matchBIntAck, err;
	reg [11:0] paddr;
	reg [31:0] pwdata, rdata, cmp;
	reg [2:0] ps;
	wire [31:0] prdata;
	wire pready, pslverr, overflowFlag, chanAMatchFlag, chanBMatchFlag;
	wire [1:0] compareOutputState, pinOut, pinOutEn, pinLevel;
	integer n_mismatch, checked, cyc, i, n;
	tcc_timer8 u_tcc_timer8 (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ovfIntAck(ovfIntAck),
		.matchAIntAck(matchAIntAck), .matchBIntAck(matchBIntAck),
		.compareOutputState(compareOutputState), .pinOut(pinOut), .pinOutEn(pinOutEn),
		.overflowFlag(overflowFlag), .chanAMatchFlag(chanAMatchFlag),
		.chanBMatchFlag(chanBMatchFlag));
	tcc_pin_load u_tcc_pin_load (.pinOut(pinOut), .pinOutEn(pinOutEn), .pinLevel(pinLevel));
	task stop_test;
	begin
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task chk(input [32:0] seen, input [32:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	end
	endtask
	task xfer(input w, input [11:0] a, input [31:0] d);
	begin
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		@(posedge ref_clk);
		while (pready !== 1'h1)
			@(posedge ref_clk);
		rdata = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	end
	endtask
	task rd(input [11:0] a, input [31:0] exp);
	begin
		xfer(1'h0, a, 32'h0);
		chk(rdata, exp);
	end
	endtask
	// cycles until the channel A state next changes
	task waitTog(output integer k);
		reg c;
	begin
		c = compareOutputState[0];
		k = 0;
		while (compareOutputState[0] === c)
		begin
			@(posedge ref_clk);
			k = k + 1;
		end
	end
	endtask
	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch = n_mismatch + 1;
			stop_test;
		end
	end
	initial
	begin
		{rst, clkEn, psel, penable, pwrite} = 5'h18;
		{ovfIntAck, matchAIntAck, matchBIntAck} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_mismatch = 0;
		checked = 0;
		cyc = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		rd(12'h000, 32'h0);
		rd(12'h018, 32'h0);
		xfer(1'h0, 12'h01C, 32'h0);
		chk({err, rdata}, 33'h100000000);
		xfer(1'h1, 12'h018, 32'h4);
		@(negedge ref_clk);
		chk(pinOutEn, 2'h1);
		@(posedge ref_clk);
		for (i = 0; i < 5; i = i + 1)
		begin
			xfer(1'h1, 12'h000, {26'h0, ACTS[4 * (4 - i) +: 2], 4'h0});
			xfer(1'h1, 12'h014, 32'h1);
			rd(12'h018, {26'h0, 1'h0, EXPS[4 - i], 4'h4});
		end
		chk(pinLevel, 2'h2);
		rd(12'h010, 32'h0);
		xfer(1'h1, 12'h008, 32'h20);
		xfer(1'h1, 12'h004, 32'h20);
		xfer(1'h1, 12'h000, 32'h100);
		repeat (4) @(posedge ref_clk);
		chk(chanAMatchFlag, 1'h0);
		xfer(1'h1, 12'h000, 32'h0);
		xfer(1'h1, 12'h004, 32'hFD);
		xfer(1'h1, 12'h000, 32'h100);
		repeat (4) @(posedge ref_clk);
		chk(overflowFlag, 1'h1);
		ovfIntAck <= 1'h1;
		repeat (2) @(posedge ref_clk);
		ovfIntAck <= 1'h0;
		repeat (6) @(posedge ref_clk);
		chk(overflowFlag, 1'h0);
		for (i = 1; i < 9; i = i + 1)
		begin
			ps = (i == 8) ? 3'h1 : i[2:0];
			cmp = (i == 8) ? 32'h3 : 32'h0;
			xfer(1'h1, 12'h008, cmp);
			xfer(1'h1, 12'h000, {21'h0, ps, 8'h12});
			waitTog(n);
			waitTog(n);
			chk(n, (1 + cmp) * (ps == 1 ? 1 : ps == 2 ? 8 : ps == 7 ? 1024 : 1 << (ps + 2)));
		end
		chk(chanAMatchFlag, 1'h1);
		xfer(1'h1, 12'h004, 32'h10);
		xfer(1'h1, 12'h010, 32'h7);
		repeat (100) @(posedge ref_clk);
		chk({overflowFlag, chanAMatchFlag, chanBMatchFlag}, 3'h0);
		repeat (200) @(posedge ref_clk);
		chk({overflowFlag, chanAMatchFlag, chanBMatchFlag}, 3'h7);
		stop_test;
	end
endmodule
